/* rtl/sps_pkg.sv */
package sps_pkg;
	////////////////////////////////////////////////////////////////////////////////
	// register map (byte addresses)
	localparam logic [7:0] CTRL_OFS    = 8'h00;
	localparam logic [7:0] CMD_OFS     = 8'h04;
	localparam logic [7:0] ELAPSED_OFS = 8'h08;
	localparam logic [7:0] OUT_OFS     = 8'h0c;
	localparam logic [7:0] SETPT_BASE  = 8'h40;
	localparam logic [7:0] STAGE_BASE  = 8'h80;
	localparam int         ADDR_W      = 8;

	// control register fields
	localparam int RUN_MODE_POS   = 0;
	localparam int RET_UNITS_POS  = 2;
	localparam int RET_TENS_POS   = 3;
	localparam int TIME_UNIT_POS  = 4;
	localparam int SEG0_SRC_POS   = 8;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;

	// command bits (write) and status fields (read)
	localparam int CMD_RUN_POS    = 0;
	localparam int CMD_STOP_POS   = 1;
	localparam int ST_RUN_POS     = 0;
	localparam int ST_HOLD_POS    = 1;
	localparam int ST_PWR_POS     = 2;
	localparam int ST_STAGE_POS   = 4;
	localparam int ST_ENTRY_POS   = 8;

	// stage register fields
	localparam int STG_TIME_POS   = 0;
	localparam int STG_ACC_POS    = 16;
	localparam logic [15:0] STG_TIME_RST = 16'h0000;
	localparam logic [1:0]  STG_ACC_RST  = 2'h0;
	localparam logic [15:0] STG_TIME_MAX = 16'hfde8;

	// setpoints in tenths of a percent
	localparam int              SP_ENTRIES = 16;
	localparam logic signed [15:0] SP_RST  = 16'sh0000;
	localparam logic signed [15:0] SP_MAX  = 16'sh03e8;
	localparam logic signed [15:0] SP_MIN  = -16'sh03e8;
	localparam logic signed [32:0] SP_FULL = 33'sh0_0000_03e8;

	// timing
	localparam int CLK_HZ          = 20_000_000;
	localparam int TENTH_S_MS      = 100;
	localparam int TENTH_S_CYC     = CLK_HZ / 1000 * TENTH_S_MS;
	localparam int TENTHS_PER_TH   = 3600;

	typedef enum logic [1:0] {
		RUN_ONESHOT,
		RUN_HOLD_LAST,
		RUN_CYCLIC
	} sps_run_mode_t;

	typedef enum logic [2:0] {
		SRC_STORED,
		SRC_AIN1,
		SRC_AIN2,
		SRC_AIN3,
		SRC_PULSE,
		SRC_PID,
		SRC_PRESET
	} sps_src_t;

	function automatic logic signed [15:0] spsClamp(input logic signed [15:0] v);
		if (v > SP_MAX) begin
			return SP_MAX;
		end else if (v < SP_MIN) begin
			return SP_MIN;
		end
		return v;
	endfunction

	// relative tenths-percent times a full-scale figure
	function automatic logic signed [16:0] spsScale(input logic signed [15:0] sp,
		input logic [15:0] full);
		logic signed [32:0] p;
		p = $signed({{17{sp[15]}}, sp}) * $signed({17'h0, full});
		return 17'(p / SP_FULL);
	endfunction

	function automatic logic [31:0] spsMerge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction
endpackage

/* rtl/sps_tick_if.sv */
`timescale 1ns/10ps
interface sps_tick_if;
	logic en;
	logic tick;
	modport drv (input en, output tick);
	modport use_side (output en, input tick);
endinterface

/* rtl/sps_tick_div.sv */
`timescale 1ns/10ps
module sps_tick_div #(
	parameter int unsigned DIV = 2
) (
	input  wire logic clk,
	input  wire logic sys_rst,
	sps_tick_if.drv   tk
);
	import sps_pkg::*;

	logic [31:0] cnt_q;
	logic        tick_q;

	// one-cycle enable pulse every DIV enabled cycles
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_q  <= 32'h0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= 1'b0;
			if (tk.en) begin
				if (cnt_q >= 32'(DIV - 1)) begin
					cnt_q  <= 32'h0;
					tick_q <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 32'h1;
				end
			end
		end
	end

	assign tk.tick = tick_q;
endmodule

/* rtl/sps_pin_sync.sv */
`timescale 1ns/10ps
module sps_pin_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic [W-1:0] pinIn,
	output logic      [W-1:0] clean
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] clean_q;

	// first stage feeds only the second
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s1_q    <= '0;
			s2_q    <= '0;
			s3_q    <= '0;
			clean_q <= '0;
		end else begin
			s1_q <= pinIn;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					clean_q[i] <= s3_q[i];
				end
			end
		end
	end

	assign clean = clean_q;
endmodule

/* rtl/sps_stage_seq.sv */
`timescale 1ns/10ps
module sps_stage_seq #(
	parameter int unsigned TENTH_DIV = sps_pkg::TENTH_S_CYC
) (
	input  wire logic                clk,
	input  wire logic                sys_rst,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [sps_pkg::ADDR_W-1:0] wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	input  wire logic [3:0]          entrySelPins,
	input  wire logic                powerLossPin,
	input  wire logic signed [15:0]  analog_input_one,
	input  wire logic signed [15:0]  analog_input_two,
	input  wire logic signed [15:0]  analog_input_three,
	input  wire logic signed [15:0]  pulse_input_terminal,
	input  wire logic signed [15:0]  pidOutput,
	input  wire logic signed [15:0]  presetFreq,
	input  wire logic [15:0]         maxFreq,
	input  wire logic [15:0]         ratedVolt,
	output logic signed [16:0]       freqSetOut,
	output logic signed [16:0]       voltSetOut,
	output logic signed [15:0]       pidRefOut,
	output logic [1:0]               rampSetSel,
	output logic                     driveRun,
	output logic                     driveReverse
);
	import sps_pkg::*;

	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_RUN,
		SEQ_HOLD
	} sps_seq_t;

	////////////////////////////////////////////////////////////////////////////////
	// pins and time base
	logic [4:0] pinClean;
	logic [3:0] termSel;
	logic       powerLost;
	logic       powerLostPrev_q;
	logic       plRise;
	logic       plFall;

	sps_pin_sync #(.W(5)) uSync (
		.clk     (clk),
		.sys_rst (sys_rst),
		.pinIn   ({powerLossPin, entrySelPins}),
		.clean   (pinClean)
	);
	assign termSel   = pinClean[3:0];
	assign powerLost = pinClean[4];

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			powerLostPrev_q <= 1'b0;
		end else begin
			powerLostPrev_q <= powerLost;
		end
	end
	assign plRise = powerLost & ~powerLostPrev_q;
	assign plFall = ~powerLost & powerLostPrev_q;

	sps_tick_if secIf ();
	sps_tick_if hourIf ();
	assign secIf.en  = 1'b1;
	assign hourIf.en = secIf.tick;

	sps_tick_div #(.DIV(TENTH_DIV)) uSecDiv (
		.clk     (clk),
		.sys_rst (sys_rst),
		.tk      (secIf)
	);
	// tenth of an hour built from tenth-second ticks
	sps_tick_div #(.DIV(TENTHS_PER_TH)) uHourDiv (
		.clk     (clk),
		.sys_rst (sys_rst),
		.tk      (hourIf)
	);

	////////////////////////////////////////////////////////////////////////////////
	// registers
	logic [31:0]        ctrl_q;
	logic signed [15:0] spTab_q [SP_ENTRIES];
	logic [15:0]        timeTab_q [SP_ENTRIES];
	logic [1:0]         accTab_q [SP_ENTRIES];
	logic               ack_q;
	logic [31:0]        rdat_q;
	logic               wrEn;
	logic               runCmd;
	logic               stopCmd;
	logic [3:0]         idx;
	logic [31:0]        wrSp;
	logic [31:0]        wrStg;
	logic [31:0]        rdMux;

	sps_run_mode_t runMode;
	sps_src_t      seg0Src;
	logic          retPower;
	logic          retStop;
	logic          timeInHours;

	assign runMode     = sps_run_mode_t'(ctrl_q[RUN_MODE_POS +: 2]);
	assign retPower    = ctrl_q[RET_UNITS_POS];
	assign retStop     = ctrl_q[RET_TENS_POS];
	assign timeInHours = ctrl_q[TIME_UNIT_POS];
	assign seg0Src     = sps_src_t'(ctrl_q[SEG0_SRC_POS +: 3]);

	// write lands on the edge where the master sees ack
	assign wrEn    = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
	assign idx     = wb_adr_i[5:2];
	assign runCmd  = wrEn && wb_adr_i == CMD_OFS && wb_sel_i[0] && wb_dat_i[CMD_RUN_POS];
	assign stopCmd = wrEn && wb_adr_i == CMD_OFS && wb_sel_i[0] && wb_dat_i[CMD_STOP_POS];
	assign wrSp    = spsMerge({{16{spTab_q[idx][15]}}, spTab_q[idx]}, wb_dat_i, wb_sel_i);
	assign wrStg   = spsMerge({14'h0, accTab_q[idx], timeTab_q[idx]}, wb_dat_i, wb_sel_i);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
		end
	end
	assign wb_ack_o = ack_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_q <= CTRL_RST;
		end else if (wrEn && wb_adr_i == CTRL_OFS) begin
			ctrl_q <= spsMerge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_071f;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < SP_ENTRIES; i++) begin
				spTab_q[i] <= SP_RST;
			end
		end else if (wrEn && wb_adr_i[7:6] == SETPT_BASE[7:6]) begin
			spTab_q[idx] <= spsClamp(wrSp[15:0]);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < SP_ENTRIES; i++) begin
				timeTab_q[i] <= STG_TIME_RST;
				accTab_q[i]  <= STG_ACC_RST;
			end
		end else if (wrEn && wb_adr_i[7:6] == STAGE_BASE[7:6]) begin
			// oversize times saturate rather than wrap
			timeTab_q[idx] <= (wrStg[15:0] > STG_TIME_MAX) ? STG_TIME_MAX
				: wrStg[STG_TIME_POS +: 16];
			accTab_q[idx]  <= wrStg[STG_ACC_POS +: 2];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// sequencer
	sps_seq_t    state_q;
	logic [3:0]  stage_q;
	logic [15:0] elapsed_q;
	logic        resume_q;
	logic        unitTick;
	logic [16:0] nextElapsed;

	assign unitTick    = timeInHours ? hourIf.tick : secIf.tick;
	assign nextElapsed = {1'b0, elapsed_q} + 17'h1;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q   <= SEQ_IDLE;
			stage_q   <= 4'h0;
			elapsed_q <= 16'h0;
			resume_q  <= 1'b0;
		end else if (plRise) begin
			resume_q <= retPower & (state_q != SEQ_IDLE);
			state_q  <= SEQ_IDLE;
			if (!retPower) begin
				stage_q   <= 4'h0;
				elapsed_q <= 16'h0;
			end
		end else if (plFall) begin
			resume_q <= 1'b0;
			if (resume_q) begin
				state_q <= SEQ_RUN;
			end
		end else if (powerLost) begin
			state_q <= SEQ_IDLE;
		end else if (stopCmd) begin
			state_q   <= SEQ_IDLE;
			resume_q  <= 1'b0;
			elapsed_q <= 16'h0;
			if (!retStop) begin
				stage_q <= 4'h0;
			end
		end else begin
			case (state_q)
				SEQ_IDLE: begin
					if (runCmd) begin
						state_q <= SEQ_RUN;
						if (!retStop) begin
							stage_q   <= 4'h0;
							elapsed_q <= 16'h0;
						end
					end
				end
				SEQ_RUN: begin
					if (unitTick) begin
						if (nextElapsed >= {1'b0, timeTab_q[stage_q]}) begin
							elapsed_q <= 16'h0;
							if (stage_q != 4'hf) begin
								stage_q <= stage_q + 4'h1;
							end else begin
								case (runMode)
									RUN_HOLD_LAST: state_q <= SEQ_HOLD;
									RUN_CYCLIC:    stage_q <= 4'h0;
									default: begin
										state_q <= SEQ_IDLE;
										stage_q <= 4'h0;
									end
								endcase
							end
						end else begin
							elapsed_q <= nextElapsed[15:0];
						end
					end
				end
				SEQ_HOLD: begin
					state_q <= SEQ_HOLD;
				end
				default: state_q <= SEQ_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// setpoint selection and scaling
	logic               seqActive;
	logic [3:0]         entry;
	logic signed [15:0] seg0Val;
	logic signed [15:0] spActive;
	logic signed [15:0] spOut_q;
	logic signed [16:0] freq_q;
	logic signed [16:0] volt_q;
	logic [1:0]         ramp_q;
	logic               run_q;

	assign seqActive = state_q != SEQ_IDLE;
	assign entry     = seqActive ? stage_q : termSel;

	always_comb begin
		case (seg0Src)
			SRC_STORED: seg0Val = spTab_q[0];
			SRC_AIN1:   seg0Val = spsClamp(analog_input_one);
			SRC_AIN2:   seg0Val = spsClamp(analog_input_two);
			SRC_AIN3:   seg0Val = spsClamp(analog_input_three);
			SRC_PULSE:  seg0Val = spsClamp(pulse_input_terminal);
			SRC_PID:    seg0Val = spsClamp(pidOutput);
			SRC_PRESET: seg0Val = spsClamp(presetFreq);
			default:    seg0Val = spTab_q[0];
		endcase
	end
	assign spActive = (entry == 4'h0) ? seg0Val : spTab_q[entry];

	// one register stage; the divide is the long path, not the table read
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			spOut_q <= SP_RST;
			freq_q  <= 17'sh0;
			volt_q  <= 17'sh0;
			ramp_q  <= 2'h0;
			run_q   <= 1'b0;
		end else begin
			spOut_q <= spActive;
			freq_q  <= spsScale(spActive, maxFreq);
			volt_q  <= spsScale(spActive, ratedVolt);
			ramp_q  <= seqActive ? accTab_q[stage_q] : 2'h0;
			run_q   <= seqActive;
		end
	end

	assign freqSetOut   = freq_q;
	assign voltSetOut   = volt_q;
	assign pidRefOut    = spOut_q;
	assign rampSetSel   = ramp_q;
	assign driveRun     = run_q;
	assign driveReverse = freq_q[16];

	////////////////////////////////////////////////////////////////////////////////
	// read path; unmapped addresses read zero
	always_comb begin
		rdMux = 32'h0;
		if (wb_adr_i[7:6] == SETPT_BASE[7:6]) begin
			rdMux = {{16{spTab_q[idx][15]}}, spTab_q[idx]};
		end else if (wb_adr_i[7:6] == STAGE_BASE[7:6]) begin
			rdMux = {14'h0, accTab_q[idx], timeTab_q[idx]};
		end else begin
			case (wb_adr_i)
				CTRL_OFS: rdMux = ctrl_q;
				CMD_OFS: begin
					rdMux[ST_RUN_POS]        = state_q == SEQ_RUN;
					rdMux[ST_HOLD_POS]       = state_q == SEQ_HOLD;
					rdMux[ST_PWR_POS]        = powerLost;
					rdMux[ST_STAGE_POS +: 4] = stage_q;
					rdMux[ST_ENTRY_POS +: 4] = entry;
				end
				ELAPSED_OFS: rdMux = {16'h0, elapsed_q};
				OUT_OFS:     rdMux = {{16{spOut_q[15]}}, spOut_q};
				default:     rdMux = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdat_q <= 32'h0;
		end else if (wb_cyc_i && wb_stb_i && !ack_q) begin
			rdat_q <= rdMux;
		end
	end
	assign wb_dat_o = rdat_q;
endmodule

/* verif/sps_seq_props.sv */
`timescale 1ns/10ps
module sps_seq_props (
	input  wire logic               clk,
	input  wire logic               sys_rst,
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_ack_o,
	input  wire logic               powerLossPin,
	input  wire logic [15:0]        maxFreq,
	input  wire logic [15:0]        ratedVolt,
	input  wire logic signed [16:0] freqSetOut,
	input  wire logic signed [16:0] voltSetOut,
	input  wire logic signed [15:0] pidRefOut,
	input  wire logic [1:0]         rampSetSel,
	input  wire logic               driveRun,
	input  wire logic               driveReverse
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////////////////////
	property p_ack_next;
		$rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after request");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack wider than one cycle");
	property p_ack_cause;
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_span;
		pidRefOut <= 16'sh03e8 && pidRefOut >= -16'sh03e8;
	endproperty
	a_span: assert property (p_span) else $error("setpoint outside span");
	// int arithmetic so the product cannot wrap
	property p_freq;
		int'(freqSetOut) == int'(pidRefOut) * int'(maxFreq) / 1000;
	endproperty
	a_freq: assert property (p_freq) else $error("frequency scaling wrong");
	property p_volt;
		int'(voltSetOut) == int'(pidRefOut) * int'(ratedVolt) / 1000;
	endproperty
	a_volt: assert property (p_volt) else $error("voltage scaling wrong");
	property p_dir;
		driveReverse == (freqSetOut != 0 && pidRefOut < 0);
	endproperty
	a_dir: assert property (p_dir) else $error("direction wrong");
	property p_ramp;
		rampSetSel != 2'h0 |-> driveRun;
	endproperty
	a_ramp: assert property (p_ramp) else $error("ramp set outside sequence");
	// pin sync (four) plus state plus output register takes six cycles, under eight
	property p_pwr;
		powerLossPin [*8] |=> !driveRun;
	endproperty
	a_pwr: assert property (p_pwr) else $error("running during power loss");
	property p_rst;
		disable iff (1'b0) sys_rst |=> !wb_ack_o && !driveRun && freqSetOut == 0;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule
bind sps_stage_seq sps_seq_props u_props (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.powerLossPin, .maxFreq, .ratedVolt, .freqSetOut, .voltSetOut, .pidRefOut, .rampSetSel,
	.driveRun, .driveReverse);

/* verif/sps_drive_model.sv */
`timescale 1ns/10ps
// front end holds its samples steady; a moving source would hide scaling slips
module sps_drive_model #(
	parameter logic signed [15:0] V1   = 16'sh0001,
	parameter logic signed [15:0] V2   = 16'sh0002,
	parameter logic signed [15:0] V3   = 16'sh0003,
	parameter logic signed [15:0] V4   = 16'sh0004,
	parameter logic signed [15:0] V5   = 16'sh0005,
	parameter logic signed [15:0] V6   = 16'sh0006,
	parameter logic [15:0]        FMAX = 16'h03e8,
	parameter logic [15:0]        VMAX = 16'h03e8
) (
	output logic signed [15:0] analog_input_one,
	output logic signed [15:0] analog_input_two,
	output logic signed [15:0] analog_input_three,
	output logic signed [15:0] pulse_input_terminal,
	output logic signed [15:0] pidOutput,
	output logic signed [15:0] presetFreq,
	output logic [15:0]        maxFreq,
	output logic [15:0]        ratedVolt
);
	assign analog_input_one = V1;
	assign analog_input_two = V2;
	assign analog_input_three = V3;
	assign pulse_input_terminal = V4;
	assign pidOutput = V5;
	assign presetFreq = V6;
	assign maxFreq = FMAX;
	assign ratedVolt = VMAX;
endmodule

/* verif/tb_multi_segment_stage_sequencer.sv */
`timescale 1ns/10ps
module tb_multi_segment_stage_sequencer;
	import sps_pkg::*;
	localparam logic signed [15:0] SV [7] = '{16'sh0064, 16'sh006f, -16'sh00de, 16'sh014d,
		16'sh01bc, -16'sh022b, 16'sh029a};
	logic               clk = 1'b0;
	logic               sys_rst = 1'b1;
	logic               wb_cyc_i = 1'b0;
	logic               wb_stb_i = 1'b0;
	logic               wb_we_i = 1'b0;
	logic [7:0]         wb_adr_i = 8'h00;
	logic [3:0]         wb_sel_i = 4'hf;
	logic [31:0]        wb_dat_i = 32'h0, wb_dat_o, r;
	logic               wb_ack_o, powerLossPin = 1'b0, driveRun, driveReverse;
	logic [3:0]         entrySelPins = 4'h0;
	logic signed [15:0] analog_input_one, analog_input_two, analog_input_three;
	logic signed [15:0] pulse_input_terminal, pidOutput, presetFreq, pidRefOut;
	logic [15:0]        maxFreq, ratedVolt;
	logic signed [16:0] freqSetOut, voltSetOut;
	logic [1:0]         rampSetSel;
	int                 fails = 0, n_checks = 0;
	sps_drive_model #(.V1(SV[1]), .V2(SV[2]), .V3(SV[3]), .V4(SV[4]), .V5(SV[5]), .V6(SV[6]),
		.FMAX(16'h1388), .VMAX(16'h0ed8)) drv (.analog_input_one, .analog_input_two,
		.analog_input_three, .pulse_input_terminal, .pidOutput, .presetFreq, .maxFreq,
		.ratedVolt);
	sps_stage_seq #(.TENTH_DIV(4)) uut (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .entrySelPins, .powerLossPin,
		.analog_input_one, .analog_input_two, .analog_input_three, .pulse_input_terminal,
		.pidOutput, .presetFreq, .maxFreq, .ratedVolt, .freqSetOut, .voltSetOut, .pidRefOut,
		.rampSetSel, .driveRun, .driveReverse);
	initial begin
		forever #25 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		$display("checks=%0d mismatches=%0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// request held until ack is sampled high; read data taken at that edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		@(posedge clk);
		// no cycle count assumed here; a missing ack is left to the watchdog
		while (wb_ack_o !== 1'b1) begin
			@(posedge clk);
		end
		r = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask
	task automatic waitSt(input logic [31:0] m, input logic [31:0] v);
		int n;
		n = 0;
		bus(1'b0, CMD_OFS, 32'h0);
		while ((r & m) !== v && n < 400) begin
			bus(1'b0, CMD_OFS, 32'h0);
			n++;
		end
		chk(r & m, v);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		bus(1'b0, CTRL_OFS, 32'h0);
		chk(r, 32'h0);
		bus(1'b0, 8'h20, 32'h0);
		chk(r, 32'h0);
		for (int i = 0; i < 16; i++) begin
			bus(1'b0, SETPT_BASE + 8'(4 * i), 32'h0);
			chk(r[15:0], 16'h0);
			bus(1'b0, STAGE_BASE + 8'(4 * i), 32'h0);
			chk(r[17:0], 18'h0);
		end
	endtask
	task automatic t_scale;
		entrySelPins <= 4'h3;
		bus(1'b1, SETPT_BASE + 8'h0c, 32'h1f4);
		repeat (8) @(posedge clk);
		chk(freqSetOut, 2500);
		chk(voltSetOut, 1900);
		chk(pidRefOut, 500);
		bus(1'b0, OUT_OFS, 32'h0);
		chk(r, 32'h1f4);
		bus(1'b1, SETPT_BASE + 8'h0c, 32'hff06);
		repeat (4) @(posedge clk);
		chk(freqSetOut, -1250);
		chk(voltSetOut, -950);
		bus(1'b1, SETPT_BASE + 8'h0c, 32'h7d0);
		bus(1'b0, SETPT_BASE + 8'h0c, 32'h0);
		chk(r[15:0], 16'h03e8);
		bus(1'b1, SETPT_BASE + 8'h0c, 32'hf830);
		bus(1'b0, SETPT_BASE + 8'h0c, 32'h0);
		chk(r[15:0], 16'hfc18);
		bus(1'b1, STAGE_BASE + 8'h38, 32'h3ffff);
		bus(1'b0, STAGE_BASE + 8'h38, 32'h0);
		chk(r[17:0], 18'h3fde8);
		bus(1'b1, STAGE_BASE + 8'h38, 32'h0);
	endtask
	task automatic t_src;
		entrySelPins <= 4'h0;
		bus(1'b1, SETPT_BASE, SV[0]);
		for (int s = 0; s < 7; s++) begin
			bus(1'b1, CTRL_OFS, 32'(s) << 8);
			repeat (6) @(posedge clk);
			chk(pidRefOut, SV[s]);
		end
	endtask
	task automatic t_modes;
		bus(1'b1, STAGE_BASE, 32'h20004);
		bus(1'b1, STAGE_BASE + 8'h14, 32'h30028);
		bus(1'b1, SETPT_BASE + 8'h14, 32'hfe70);
		bus(1'b1, SETPT_BASE + 8'h3c, 32'h12c);
		bus(1'b1, CTRL_OFS, 32'h0);
		bus(1'b1, CMD_OFS, 32'h1);
		waitSt(32'hf1, 32'h51);
		chk(rampSetSel, 2'h3);
		chk(pidRefOut, -400);
		chk(driveReverse, 1'b1);
		waitSt(32'h1, 32'h0);
		chk(r[7:4], 4'h0);
		repeat (20) @(posedge clk);
		chk(driveRun, 1'b0);
		bus(1'b1, CTRL_OFS, 32'h1);
		bus(1'b1, CMD_OFS, 32'h1);
		waitSt(32'h2, 32'h2);
		chk(r[7:4], 4'hf);
		chk(driveRun, 1'b1);
		chk(freqSetOut, 1500);
		bus(1'b1, CMD_OFS, 32'h2);
		bus(1'b1, CTRL_OFS, 32'h2);
		bus(1'b1, CMD_OFS, 32'h1);
		waitSt(32'hf0, 32'h50);
		waitSt(32'hf1, 32'h01);
		bus(1'b1, CMD_OFS, 32'h2);
	endtask
	// retained position must survive stop and power loss; a dropped one reads back as stage zero
	task automatic t_keep(input logic [31:0] c, input logic p, input logic [3:0] e);
		bus(1'b1, CTRL_OFS, c);
		bus(1'b1, CMD_OFS, 32'h1);
		waitSt(32'hf0, 32'h50);
		powerLossPin <= p;
		if (p === 1'b0) bus(1'b1, CMD_OFS, 32'h2);
		repeat (10) @(posedge clk);
		chk(driveRun, 1'b0);
		powerLossPin <= 1'b0;
		if (p === 1'b0) bus(1'b1, CMD_OFS, 32'h1);
		repeat (10) @(posedge clk);
		bus(1'b0, CMD_OFS, 32'h0);
		chk(r[7:4], e);
		bus(1'b1, CMD_OFS, 32'h2);
	endtask
	task automatic t_hours;
		bus(1'b1, STAGE_BASE, 32'h20001);
		bus(1'b1, CTRL_OFS, 32'h10);
		bus(1'b1, CMD_OFS, 32'h1);
		repeat (2000) @(posedge clk);
		bus(1'b0, CMD_OFS, 32'h0);
		chk(r[7:0], 8'h01);
		bus(1'b0, ELAPSED_OFS, 32'h0);
		chk(r, 32'h0);
		bus(1'b1, CMD_OFS, 32'h2);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#(50 * 40000);
		fails++;
		end_of_test();
	end
	initial begin
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_scale();
		t_src();
		t_modes();
		t_keep(32'h9, 1'b0, 4'h5);
		t_keep(32'h1, 1'b0, 4'h0);
		t_keep(32'h5, 1'b1, 4'h5);
		t_keep(32'h1, 1'b1, 4'h0);
		t_hours();
		end_of_test();
	end
endmodule
